/* File: logic/startup_config_decoder.sv */
// Startup configuration decoder and database acquisition sequencer.
// Assumes load and sumcheck engines answer each go pulse with one done.
`timescale 1ns/1ns
`default_nettype none
module startup_config_decoder
   import startup_cfg_pkg::*;
(
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic [7:0] config_switchbank_a,
   input wire logic [7:0] node_address_switchbank,
   input wire logic medium_jumper,
   input wire logic [7:0] instr_no,
   input wire logic cpu_healthy,
   input wire logic user_alarm_flag,
   input wire logic task_stopped,
   input wire logic db_halt,
   input wire logic peer_time_valid,
   input wire logic [15:0] outage_time,
   input wire logic [15:0] cold_start_threshold,
   input wire logic [7:0] run_file_count,
   input wire logic load_done,
   input wire logic load_ok,
   input wire logic sum_done,
   input wire logic sum_ok,
   output logic cfg_valid,
   output logic [2:0] strategy_num,
   output logic [7:0] node_addr,
   output logic node_addr_bad,
   output comms_t comms,
   output logic [6:0] bin_addr,
   output logic bin_addr_ok,
   output logic isb_enable,
   output logic outputs_killed,
   output logic tasks_run,
   output logic startup_idle,
   output logic load_go,
   output db_src_t load_src,
   output logic sum_go,
   output logic relay_closed
);

   // ------------------------------------------------------------
   // Configuration capture
   // ------------------------------------------------------------
   start_cfg_t scfg;
   start_cfg_t next_scfg;
   logic next_cfg_valid;
   logic [2:0] next_strategy_num;
   logic [7:0] next_node_addr;
   logic next_node_addr_bad;
   comms_t next_comms;
   logic [6:0] next_bin_addr;
   logic next_bin_addr_ok;

   always_comb
   begin
      next_scfg = scfg;
      next_cfg_valid = 1'b1;
      next_strategy_num = strategy_num;
      next_node_addr = node_addr;
      next_node_addr_bad = node_addr_bad;
      next_comms = comms;
      if (!cfg_valid)
      begin
         next_scfg.cold = config_switchbank_a[SW_COLD];
         next_scfg.warm = config_switchbank_a[SW_WARM];
         next_scfg.task_wd = config_switchbank_a[SW_TASK_WD];
         next_strategy_num = STRAT_NONE;
         for (int i = 0; i < STRAT_SW_N; i++)
         begin
            if (config_switchbank_a[SW_STRAT0 + i])
               next_strategy_num = 3'(next_strategy_num + STRAT_W[i]);
         end
         next_node_addr = node_address_switchbank;
         next_node_addr_bad = (node_address_switchbank == NODE_RSVD_LO) ||
                              (node_address_switchbank == NODE_RSVD_HI);
         next_comms.ext_isb = config_switchbank_a[SW_COMM2];
         next_comms.modbus = !config_switchbank_a[SW_COMM2] &&
                             config_switchbank_a[SW_COMM1];
         next_comms.rs485 = medium_jumper;
      end
      next_bin_addr = bin_addr;
      next_bin_addr_ok = 1'b0;
      if (cfg_valid && !comms.modbus && !comms.ext_isb && instr_no <= BIN_ADDR_MAX)
      begin
         next_bin_addr = instr_no[6:0];
         next_bin_addr_ok = 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         scfg <= START_CFG_RST;
         cfg_valid <= 1'b0;
         strategy_num <= STRAT_NONE;
         node_addr <= NODE_RSVD_LO;
         node_addr_bad <= 1'b0;
         comms <= COMMS_RST;
         bin_addr <= 7'h00;
         bin_addr_ok <= 1'b0;
      end
      else
      begin
         scfg <= next_scfg;
         cfg_valid <= next_cfg_valid;
         strategy_num <= next_strategy_num;
         node_addr <= next_node_addr;
         node_addr_bad <= next_node_addr_bad;
         comms <= next_comms;
         bin_addr <= next_bin_addr;
         bin_addr_ok <= next_bin_addr_ok;
      end
   end

   // ------------------------------------------------------------
   // Database acquisition sequencer
   // ------------------------------------------------------------
   typedef enum logic [3:0] {
      S_SAMPLE, S_ISB, S_DECIDE, S_WARM, S_TEPID, S_CLEAR, S_COLD,
      S_STRAT, S_EMPTY, S_SUM, S_RUN, S_IDLE
   } seq_state_t;

   seq_state_t state;
   seq_state_t next_state;
   logic sent;
   logic next_sent;
   logic next_isb_enable;
   logic next_tasks_run;
   logic next_startup_idle;
   logic next_load_go;
   db_src_t next_load_src;
   logic next_sum_go;
   logic short_outage;

   assign short_outage = outage_time < cold_start_threshold;

   always_comb
   begin
      next_state = state;
      next_sent = sent;
      next_isb_enable = isb_enable;
      next_tasks_run = tasks_run;
      next_startup_idle = startup_idle;
      next_load_go = 1'b0;
      next_load_src = load_src;
      next_sum_go = 1'b0;
      unique case (state)
         S_SAMPLE:
            next_state = S_ISB;
         S_ISB:
         begin
            next_isb_enable = 1'b1;
            next_state = S_DECIDE;
         end
         S_DECIDE:
         begin
            if (!scfg.cold && !scfg.warm)
               next_state = S_IDLE;
            else if (!scfg.cold)
               next_state = S_WARM;
            else if (!scfg.warm)
               next_state = S_COLD;
            else if (!peer_time_valid)
               next_state = S_TEPID;
            else if (short_outage)
               next_state = S_WARM;
            else
               next_state = S_COLD;
         end
         S_WARM:
         begin
            if (!sent)
            begin
               next_sum_go = 1'b1;
               next_load_src = SRC_RAM;
               next_sent = 1'b1;
            end
            else if (sum_done)
            begin
               next_sent = 1'b0;
               next_state = sum_ok ? S_RUN : S_TEPID;
            end
         end
         S_TEPID:
         begin
            if (!sent)
            begin
               next_load_go = 1'b1;
               next_load_src = SRC_TEPID;
               next_sent = 1'b1;
            end
            else if (load_done)
            begin
               next_sent = 1'b0;
               next_state = load_ok ? S_SUM : S_CLEAR;
            end
         end
         S_CLEAR:
         begin
            if (!sent)
            begin
               next_load_go = 1'b1;
               next_load_src = SRC_CLEAR;
               next_sent = 1'b1;
            end
            else if (load_done)
            begin
               next_sent = 1'b0;
               next_state = scfg.cold ? S_COLD : S_IDLE;
            end
         end
         S_COLD:
         begin
            if (run_file_count != RUN_FILES_ONE)
               next_state = S_STRAT;
            else if (!sent)
            begin
               next_load_go = 1'b1;
               next_load_src = SRC_NV;
               next_sent = 1'b1;
            end
            else if (load_done)
            begin
               next_sent = 1'b0;
               next_state = load_ok ? S_SUM : S_STRAT;
            end
         end
         S_STRAT:
         begin
            if (strategy_num == STRAT_NONE)
               next_state = S_IDLE;
            else if (strategy_num > STRAT_MAX)
               next_state = S_EMPTY;
            else if (!sent)
            begin
               next_load_go = 1'b1;
               next_load_src = SRC_STRAT;
               next_sent = 1'b1;
            end
            else if (load_done)
            begin
               next_sent = 1'b0;
               next_state = load_ok ? S_SUM : S_EMPTY;
            end
         end
         S_EMPTY:
         begin
            if (!sent)
            begin
               next_load_go = 1'b1;
               next_load_src = SRC_EMPTY;
               next_sent = 1'b1;
            end
            else if (load_done)
            begin
               next_sent = 1'b0;
               next_state = S_SUM;
            end
         end
         S_SUM:
         begin
            if (!sent)
            begin
               next_sum_go = 1'b1;
               next_sent = 1'b1;
            end
            else if (sum_done)
            begin
               next_sent = 1'b0;
               next_state = sum_ok ? S_RUN : S_IDLE;
            end
         end
         S_RUN:
            next_tasks_run = 1'b1;
         S_IDLE:
            next_startup_idle = 1'b1;
      endcase
   end

   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         state <= S_SAMPLE;
         sent <= 1'b0;
         isb_enable <= 1'b0;
         tasks_run <= 1'b0;
         startup_idle <= 1'b0;
         outputs_killed <= 1'b1;
         load_go <= 1'b0;
         load_src <= SRC_NONE;
         sum_go <= 1'b0;
      end
      else
      begin
         state <= next_state;
         sent <= next_sent;
         isb_enable <= next_isb_enable;
         tasks_run <= next_tasks_run;
         startup_idle <= next_startup_idle;
         outputs_killed <= !next_tasks_run;
         load_go <= next_load_go;
         load_src <= next_load_src;
         sum_go <= next_sum_go;
      end
   end

   // ------------------------------------------------------------
   // Watchdog relay
   // ------------------------------------------------------------
   watchdog_relay u_relay (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .task_wd(scfg.task_wd),
      .cpu_healthy(cpu_healthy),
      .user_alarm_flag(user_alarm_flag),
      .task_stopped(task_stopped),
      .db_halt(db_halt),
      .relay_closed(relay_closed)
   );

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   property p_strat_sum;
      @(posedge sys_clk) disable iff (!nrst)
      $rose(cfg_valid) |-> strategy_num ==
         3'({2'b00, $past(config_switchbank_a[5])} +
            {1'b0, $past(config_switchbank_a[6]), 1'b0} +
            {$past(config_switchbank_a[7]), 2'b00});
   endproperty
   a_strat_sum: assert property (p_strat_sum)
      else $error("Strategy number is not the weighted switch sum.");

   property p_no_strat;
      @(posedge sys_clk) disable iff (!nrst)
      (load_go && load_src == SRC_STRAT) |->
         (strategy_num != STRAT_NONE && strategy_num <= STRAT_MAX);
   endproperty
   a_no_strat: assert property (p_no_strat)
      else $error("Strategy load issued with no valid strategy.");

   property p_node;
      @(posedge sys_clk) disable iff (!nrst)
      $rose(cfg_valid) |-> node_addr == $past(node_address_switchbank);
   endproperty
   a_node: assert property (p_node)
      else $error("Node address differs from the switchbank.");

   property p_comms;
      @(posedge sys_clk) disable iff (!nrst)
      $rose(cfg_valid) |-> comms.modbus ==
         (!$past(config_switchbank_a[1]) && $past(config_switchbank_a[0]));
   endproperty
   a_comms: assert property (p_comms)
      else $error("Protocol select does not follow the comms switches.");

   property p_killed;
      @(posedge sys_clk) disable iff (!nrst)
      !tasks_run |-> (outputs_killed && (isb_enable || state <= S_ISB));
   endproperty
   a_killed: assert property (p_killed)
      else $error("Outputs released or bus off before tasks run.");

   property p_sum_first;
      @(posedge sys_clk) disable iff (!nrst)
      $rose(tasks_run) |-> $past(state, 2) inside {S_SUM, S_WARM};
   endproperty
   a_sum_first: assert property (p_sum_first)
      else $error("Tasks started without a passing sumcheck.");

   property p_idle_off;
      @(posedge sys_clk) disable iff (!nrst)
      (cfg_valid && !scfg.cold && !scfg.warm) |-> !load_go && !sum_go;
   endproperty
   a_idle_off: assert property (p_idle_off)
      else $error("Database acquired with both start switches off.");

   property p_hold;
      @(posedge sys_clk) disable iff (!nrst)
      (cfg_valid && $past(cfg_valid)) |-> $stable(node_addr) && $stable(scfg);
   endproperty
   a_hold: assert property (p_hold)
      else $error("Configuration changed after capture.");

endmodule
`default_nettype wire

/* File: logic/startup_cfg_pkg.sv */
// Constants, field positions and carrier types for the startup decoder.
// Assumes switch bit 0 is switch 1 of each bank and on reads as one.
// How it works
// - Strategy number is sum of switch weights.
// - All strategy switches off loads no strategy.
// - Task-halt switch adds task and database halts.
// - Relay closed when healthy; opens on failure, alarm.
// - Node address switch 1 LSB, switch 8 MSB.
// - Comms switch 1 picks binary or Modbus.
// - Comms switch 2 selects external bus, ignores 1.
// - Medium jumper fitted means RS485, else RS422.
// - Binary address accepted only from 0 to 127.
// - I/O outputs start killed at power-up.
// - Bus starts first; outputs unwritten until tasks run.
// - Warm: run intact RAM, else tepid reload.
// - Cold: nonvolatile, then strategy, then empty database.
// - Both start switches on and no peer time takes the alternative warm path.
// - Every loaded database is sumchecked before use.
// - Strategies are numbered one to four.
// - Both start switches off: idle, no load.
// - Warm only: resume, else tepid, else clear, idle.
// - Cold only: nonvolatile load only with exactly one file.
// - Both on with peer time: short outage warm, long outage cold.
package startup_cfg_pkg;

   // ------------------------------------------------------------
   // Switch positions in the configuration bank
   // ------------------------------------------------------------
   localparam int SW_COMM1 = 0;
   localparam int SW_COMM2 = 1;
   localparam int SW_COLD = 2;
   localparam int SW_WARM = 3;
   localparam int SW_TASK_WD = 4;
   localparam int SW_STRAT0 = 5;
   localparam int STRAT_SW_N = 3;

   // ------------------------------------------------------------
   // Values and limits
   // ------------------------------------------------------------
   localparam logic [2:0] STRAT_W [STRAT_SW_N] = '{3'h1, 3'h2, 3'h4};
   localparam logic [2:0] STRAT_NONE = 3'h0;
   localparam logic [2:0] STRAT_MAX = 3'h4;
   localparam logic [7:0] NODE_RSVD_LO = 8'h00;
   localparam logic [7:0] NODE_RSVD_HI = 8'hff;
   localparam logic [7:0] BIN_ADDR_MAX = 8'h7f;
   localparam logic [7:0] RUN_FILES_ONE = 8'h01;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      SRC_NONE, SRC_RAM, SRC_TEPID, SRC_NV, SRC_STRAT, SRC_CLEAR, SRC_EMPTY
   } db_src_t;

   typedef struct packed {
      logic cold;
      logic warm;
      logic task_wd;
   } start_cfg_t;

   typedef struct packed {
      logic modbus;
      logic ext_isb;
      logic rs485;
   } comms_t;

   localparam start_cfg_t START_CFG_RST = '0;
   localparam comms_t COMMS_RST = '0;

endpackage

/* File: logic/watchdog_relay.sv */
// Watchdog relay drive for the startup decoder.
// Assumes the health, alarm and halt levels are synchronous to sys_clk.
`timescale 1ns/1ns
`default_nettype none
module watchdog_relay
   import startup_cfg_pkg::*;
(
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic task_wd,
   input wire logic cpu_healthy,
   input wire logic user_alarm_flag,
   input wire logic task_stopped,
   input wire logic db_halt,
   output logic relay_closed
);

   logic next_relay_closed;

   // ------------------------------------------------------------
   // Relay decision
   // ------------------------------------------------------------
   always_comb
   begin
      next_relay_closed = cpu_healthy && !user_alarm_flag;
      if (task_wd && (task_stopped || db_halt))
      begin
         next_relay_closed = 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
         relay_closed <= 1'b0;
      else
         relay_closed <= next_relay_closed;
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   property p_relay_fail;
      @(posedge sys_clk) disable iff (!nrst)
      (!cpu_healthy || user_alarm_flag) |=> !relay_closed;
   endproperty
   a_relay_fail: assert property (p_relay_fail)
      else $error("Relay closed on failure or alarm.");

   property p_relay_halt;
      @(posedge sys_clk) disable iff (!nrst)
      (task_wd && (task_stopped || db_halt)) |=> !relay_closed;
   endproperty
   a_relay_halt: assert property (p_relay_halt)
      else $error("Relay closed on halt with watchdog switch on.");

   property p_relay_ignore;
      @(posedge sys_clk) disable iff (!nrst)
      (!task_wd && cpu_healthy && !user_alarm_flag) |=> relay_closed;
   endproperty
   a_relay_ignore: assert property (p_relay_ignore)
      else $error("Relay opened on halt with watchdog switch off.");

endmodule
`default_nettype wire

/* File: tb/mem_engine_model.sv */
// Model of the memory module engines that answer load and sumcheck requests.
// Assumes the bench sets outcome tables and delay while reset is held.
`timescale 1ns/1ns
`default_nettype none
module mem_engine_model
   import startup_cfg_pkg::*;
(
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic load_go,
   input wire db_src_t load_src,
   input wire logic sum_go,
   input wire logic [7:0] lok,
   input wire logic [7:0] sok,
   input wire logic [3:0] dly,
   output logic load_done,
   output logic load_ok,
   output logic sum_done,
   output logic sum_ok
);
   logic [4:0] lcnt;
   logic [4:0] scnt;
   db_src_t lsrc;
   db_src_t ssrc;

   // ------------------------------------------------------------
   // Request capture
   // ------------------------------------------------------------
   always @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         lcnt <= 5'h00;
         scnt <= 5'h00;
      end
      else
      begin
         lcnt <= load_go ? 5'(dly) + 5'h01 : (lcnt != 5'h00 ? lcnt - 5'h01 : lcnt);
         scnt <= sum_go ? 5'(dly) + 5'h01 : (scnt != 5'h00 ? scnt - 5'h01 : scnt);
         if (load_go) lsrc <= load_src;
         if (sum_go) ssrc <= load_src;
      end
   end

   // ------------------------------------------------------------
   // Answers, one done per request
   // ------------------------------------------------------------
   always @(negedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         load_done <= 1'b0;
         sum_done <= 1'b0;
         load_ok <= 1'b0;
         sum_ok <= 1'b0;
      end
      else
      begin
         load_done <= (lcnt == 5'h01);
         sum_done <= (scnt == 5'h01);
         // Result lines toggle outside the done cycle.
         load_ok <= (lcnt == 5'h01) ? lok[lsrc] : ~load_ok;
         sum_ok <= (scnt == 5'h01) ? sok[ssrc] : ~sum_ok;
      end
   end
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
// Self-checking bench for the startup decoder and its engine model.
// Assumes the package, decoder and engine model compile ahead of it.
`timescale 1ns/1ns
`default_nettype none
module tb_top
   import startup_cfg_pkg::*;
;
   logic sys_clk = 1'b0, nrst = 1'b0, medium_jumper = 1'b0, peer_time_valid = 1'b0;
   logic cpu_healthy = 1'b1, user_alarm_flag = 1'b0, task_stopped = 1'b0, db_halt = 1'b0;
   logic [7:0] cfg_a = 8'h00, node_sw = 8'h01, instr_no = 8'h00, run_file_count = 8'h00;
   logic [7:0] lok = 8'hff, sok = 8'hff;
   logic [15:0] outage_time = 16'h0000, cold_start_threshold = 16'h0000;
   logic [3:0] dly = 4'h0;
   logic load_done, load_ok, sum_done, sum_ok, cfg_valid, node_addr_bad, bin_addr_ok;
   logic isb_enable, outputs_killed, tasks_run, startup_idle, load_go, sum_go, relay_closed;
   logic [2:0] strategy_num;
   logic [7:0] node_addr;
   logic [6:0] bin_addr;
   comms_t comms;
   db_src_t load_src;
   int err_total = 0, total_checks = 0, cyc = 0;
   int exp_q[$];
   logic [31:0] rng = 32'hf8eb;

   startup_config_decoder u_startup_config_decoder (.sys_clk(sys_clk), .nrst(nrst),
      .config_switchbank_a(cfg_a), .node_address_switchbank(node_sw),
      .medium_jumper(medium_jumper), .instr_no(instr_no), .cpu_healthy(cpu_healthy),
      .user_alarm_flag(user_alarm_flag), .task_stopped(task_stopped), .db_halt(db_halt),
      .peer_time_valid(peer_time_valid), .outage_time(outage_time),
      .cold_start_threshold(cold_start_threshold), .run_file_count(run_file_count),
      .load_done(load_done), .load_ok(load_ok), .sum_done(sum_done), .sum_ok(sum_ok),
      .cfg_valid(cfg_valid), .strategy_num(strategy_num), .node_addr(node_addr),
      .node_addr_bad(node_addr_bad), .comms(comms), .bin_addr(bin_addr),
      .bin_addr_ok(bin_addr_ok), .isb_enable(isb_enable), .outputs_killed(outputs_killed),
      .tasks_run(tasks_run), .startup_idle(startup_idle), .load_go(load_go),
      .load_src(load_src), .sum_go(sum_go), .relay_closed(relay_closed));

   mem_engine_model u_mem_engine_model (.sys_clk(sys_clk), .nrst(nrst), .load_go(load_go),
      .load_src(load_src), .sum_go(sum_go), .lok(lok), .sok(sok), .dly(dly),
      .load_done(load_done), .load_ok(load_ok), .sum_done(sum_done), .sum_ok(sum_ok));

   always #50 sys_clk = ~sys_clk;

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic print_verdict();
      $display("checks %0d, mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   always @(posedge sys_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 5000)
      begin
         err_total++;
         print_verdict();
      end
   end

   function automatic logic [31:0] rnd();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng;
   endfunction

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask

   // Events: load source, 8 plus source for a sumcheck, 16 run, 17 idle.
   task automatic model(input logic w, c, input int st, rfc, input logic pv, sh);
      int s;
      int fin;
      fin = 0;
      exp_q = {};
      if (!w && !c) fin = 17;
      if (w && (!c || !pv || sh))
      begin
         if (!(c && !pv))
         begin
            exp_q.push_back(8 + SRC_RAM);
            if (sok[SRC_RAM]) fin = 16;
         end
         if (fin == 0)
         begin
            exp_q.push_back(SRC_TEPID);
            if (lok[SRC_TEPID])
            begin
               exp_q.push_back(8 + SRC_TEPID);
               fin = sok[SRC_TEPID] ? 16 : 17;
            end
            else
            begin
               exp_q.push_back(SRC_CLEAR);
               if (!c) fin = 17;
            end
         end
      end
      if (fin == 0 && rfc == 1)
      begin
         exp_q.push_back(SRC_NV);
         if (lok[SRC_NV])
         begin
            exp_q.push_back(8 + SRC_NV);
            fin = sok[SRC_NV] ? 16 : 17;
         end
      end
      if (fin == 0)
      begin
         s = (st > 4) ? SRC_EMPTY : SRC_STRAT;
         if (st == 0) fin = 17;
         else
         begin
            exp_q.push_back(s);
            if (s == SRC_STRAT && !lok[SRC_STRAT])
            begin
               s = SRC_EMPTY;
               exp_q.push_back(s);
            end
            exp_q.push_back(8 + s);
            fin = sok[s] ? 16 : 17;
         end
      end
      exp_q.push_back(fin);
   endtask

   task automatic run_case(input logic w, c, input logic [2:0] st, input int rfc,
      input logic pv, sh, input logic [7:0] lk, sk, nd);
      logic [7:0] a;
      logic [31:0] r;
      logic rr;
      int ev;
      int n;
      @(negedge sys_clk);
      nrst = 1'b0;
      r = rnd();
      a = {st, r[4], w, c, r[1:0]};
      cfg_a = a;
      node_sw = nd;
      instr_no = r[15:8];
      medium_jumper = r[16];
      dly = r[20:17];
      lok = lk;
      sok = sk;
      run_file_count = rfc[7:0];
      peer_time_valid = pv;
      cold_start_threshold = 16'h0100;
      outage_time = sh ? 16'h00ff : 16'h0100;
      {cpu_healthy, user_alarm_flag, task_stopped, db_halt} = 4'h8;
      model(w, c, st, rfc, pv, sh);
      repeat (4) @(negedge sys_clk);
      check(outputs_killed, 8'h01);
      nrst = 1'b1;
      @(negedge sys_clk);
      check(cfg_valid, 8'h01);
      check(strategy_num, 8'(a[5] + 2 * a[6] + 4 * a[7]));
      check(node_addr, nd);
      check(node_addr_bad, nd == 8'h00 || nd == 8'hff);
      check(comms, {~a[1] & a[0], a[1], medium_jumper});
      @(negedge sys_clk);
      check(bin_addr_ok, !a[1] && !a[0] && instr_no <= 8'h7f);
      if (bin_addr_ok === 1'b1) check(bin_addr, instr_no[6:0]);
      n = 0;
      while (n < 300 && exp_q.size() > 0)
      begin
         @(negedge sys_clk);
         n++;
         ev = -1;
         if (load_go === 1'b1) ev = load_src;
         else if (sum_go === 1'b1) ev = 8 + load_src;
         else if (tasks_run === 1'b1) ev = 16;
         else if (startup_idle === 1'b1) ev = 17;
         if (ev >= 0) check(ev[7:0], 8'(exp_q.pop_front()));
      end
      check(exp_q.size(), 8'h00);
      check(outputs_killed, 8'(ev != 16));
      check(isb_enable, 8'h01);
      r = rnd();
      cfg_a = r[7:0];
      node_sw = r[15:8];
      repeat (2) @(negedge sys_clk);
      check(node_addr, nd);
      check(strategy_num, 8'(st));
      for (int i = 0; i < 6; i++)
      begin
         r = rnd();
         {cpu_healthy, user_alarm_flag, task_stopped, db_halt} = r[3:0];
         rr = r[3] & !r[2] & !(a[4] & (r[1] | r[0]));
         @(negedge sys_clk);
         check(relay_closed, rr);
      end
      $display("case done, %0d checks so far", total_checks);
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   // Node addresses 00 and ff appear only in the first two cases.
   initial
   begin
      run_case(0, 0, 3'h3, 1, 1, 1, 8'hff, 8'hff, 8'h00);
      run_case(1, 0, 3'h0, 0, 1, 1, 8'hff, 8'hff, 8'hff);
      run_case(1, 0, 3'h0, 0, 1, 1, 8'hff, 8'hfd, 8'h7a);
      run_case(1, 0, 3'h0, 0, 1, 1, 8'hfb, 8'hfd, 8'h01);
      run_case(0, 1, 3'h0, 1, 1, 1, 8'hff, 8'hff, 8'hfe);
      run_case(0, 1, 3'h0, 1, 1, 1, 8'hff, 8'hf7, 8'h80);
      run_case(0, 1, 3'h3, 2, 1, 1, 8'hff, 8'hff, 8'h3c);
      run_case(0, 1, 3'h0, 0, 1, 1, 8'hff, 8'hff, 8'hc3);
      run_case(0, 1, 3'h5, 0, 1, 1, 8'hff, 8'hff, 8'h55);
      run_case(0, 1, 3'h4, 1, 1, 1, 8'he7, 8'hff, 8'haa);
      run_case(1, 1, 3'h0, 0, 1, 1, 8'hff, 8'hff, 8'h12);
      run_case(1, 1, 3'h0, 1, 1, 0, 8'hff, 8'hff, 8'h34);
      run_case(1, 1, 3'h2, 0, 0, 1, 8'hfb, 8'hff, 8'h56);
      run_case(1, 1, 3'h0, 1, 1, 1, 8'hfb, 8'hfd, 8'h78);
      print_verdict();
   end
endmodule
`default_nettype wire
